// file: design/slt_top.sv
// channel allocation, stream handshake and bring-up status of the link transmitter
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`default_nettype none
module slt_top (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pll_lock,
    input wire logic pll_not_locked,
    output logic transceiver_reset,
    output logic [2:0] loopback_mode,
    output logic tx_lock,
    output logic tx_reset_done,
    output logic rx_reset_done,
    output logic lane_up,
    output logic channel_up,
    input wire logic clock_correction_request,
    input wire logic nfc_tx_tvalid,
    input wire logic ufc_tx_req,
    input wire logic user_k_tx_tvalid,
    input wire logic [slt_pkg::DATA_W-1:0] s_tx_tdata,
    input wire logic [slt_pkg::KEEP_W-1:0] s_tx_tkeep,
    input wire logic s_tx_tlast,
    input wire logic s_tx_tvalid,
    output logic s_tx_tready,
    input wire logic flow_stop_message,
    input wire logic flow_resume_message,
    input wire logic [slt_pkg::DATA_W-1:0] link_rx_tdata,
    input wire logic [slt_pkg::KEEP_W-1:0] link_rx_tkeep,
    input wire logic link_rx_tlast,
    input wire logic link_rx_tvalid,
    output logic [slt_pkg::DATA_W-1:0] m_rx_tdata,
    output logic [slt_pkg::KEEP_W-1:0] m_rx_tkeep,
    output logic m_rx_tlast,
    output logic m_rx_tvalid,
    output logic [2:0] chan_kind,
    output logic [slt_pkg::DATA_W-1:0] chan_tdata,
    output logic [slt_pkg::KEEP_W-1:0] chan_tkeep,
    output logic chan_tlast
);
    localparam int FW = slt_pkg::DATA_W + slt_pkg::KEEP_W + 1;

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic ctrl_reset;
        logic [2:0] loop;
        logic xcvr_reset;
        logic tx_lock;
        logic flow_stopped;
        logic tx_ready;
        logic [2:0] kind;
        logic [slt_pkg::DATA_W-1:0] cdata;
        logic [slt_pkg::KEEP_W-1:0] ckeep;
        logic clast;
        logic [slt_pkg::DATA_W-1:0] rxd;
        logic [slt_pkg::KEEP_W-1:0] rxk;
        logic rxl;
        logic rxv;
    } slt_top_state_type;

    slt_top_state_type s;
    slt_top_state_type next_s;
    logic lock_ok;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [FW-1:0] fifo_out;
    logic [slt_pkg::LEVEL_W-1:0] fifo_level;
    logic [31:0] status_word;
    logic [2:0] wr_loop;

    ////////////////////////////////////////////////////////////////////////////
    // bring-up chain, each step starts when the one before is done
    assign lock_ok = s.tx_lock && !pll_not_locked && !s.ctrl_reset;

    slt_delay #(.CYCLES(slt_pkg::TX_RST_CYC)) u_tx_step (
        .ref_clk(ref_clk), .nrst(nrst), .start(lock_ok), .done(tx_reset_done)
    );
    slt_delay #(.CYCLES(slt_pkg::RX_RST_CYC)) u_rx_step (
        .ref_clk(ref_clk), .nrst(nrst), .start(lock_ok && tx_reset_done),
        .done(rx_reset_done)
    );
    slt_delay #(.CYCLES(slt_pkg::LANE_CYC)) u_lane_step (
        .ref_clk(ref_clk), .nrst(nrst), .start(lock_ok && rx_reset_done),
        .done(lane_up)
    );
    slt_delay #(.CYCLES(slt_pkg::CHAN_CYC)) u_chan_step (
        .ref_clk(ref_clk), .nrst(nrst), .start(lock_ok && lane_up),
        .done(channel_up)
    );

    ////////////////////////////////////////////////////////////////////////////
    // transmit buffer between user stream and channel
    slt_fifo #(.WIDTH(FW), .DEPTH(slt_pkg::FIFO_DEPTH)) u_tx_fifo (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .in_valid(s_tx_tvalid && s.tx_ready),
        .in_ready(fifo_in_ready),
        .in_data({s_tx_tdata, s_tx_tkeep, s_tx_tlast}),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out),
        .level(fifo_level)
    );

    assign status_word = {20'h0, fifo_level, 2'h0, s.flow_stopped, channel_up,
                          lane_up, rx_reset_done, tx_reset_done, s.tx_lock};
    assign wr_loop = s.w_data[slt_pkg::CTRL_LOOP_LSB +: 3];
    assign fifo_pop = channel_up && !clock_correction_request && !nfc_tx_tvalid
        && !ufc_tx_req && !user_k_tx_tvalid && !s.flow_stopped && fifo_out_valid;

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_s = s;
        // register bus write
        if (s_axi_awvalid && s.awready) begin
            next_s.aw_have = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            next_s.w_have = 1'b1;
            next_s.w_data = s_axi_wdata;
            next_s.w_strb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.aw_have && s.w_have && !s.bvalid) begin
            next_s.aw_have = 1'b0;
            next_s.w_have = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = slt_pkg::RESP_OKAY;
            if (s.aw_addr == slt_pkg::REG_CTRL) begin
                if (s.w_strb[0]) begin
                    next_s.ctrl_reset = s.w_data[slt_pkg::CTRL_RESET_BIT];
                    if (wr_loop <= slt_pkg::LOOP_MAX) begin
                        next_s.loop = wr_loop;
                    end
                end
            end else if (s.aw_addr != slt_pkg::REG_STATUS) begin
                next_s.bresp = slt_pkg::RESP_SLVERR;
            end
        end
        next_s.awready = !next_s.aw_have && !next_s.bvalid;
        next_s.wready = !next_s.w_have && !next_s.bvalid;
        // register bus read
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = slt_pkg::RESP_OKAY;
            if (s_axi_araddr == slt_pkg::REG_CTRL) begin
                next_s.rdata = {28'h0, s.loop, s.ctrl_reset};
            end else if (s_axi_araddr == slt_pkg::REG_STATUS) begin
                next_s.rdata = status_word;
            end else begin
                next_s.rdata = 32'h0;
                next_s.rresp = slt_pkg::RESP_SLVERR;
            end
        end
        next_s.arready = !next_s.rvalid;
        // lock and transceiver reset
        next_s.tx_lock = pll_lock;
        next_s.xcvr_reset = s.ctrl_reset || pll_not_locked;
        // remote flow messages, stop wins a tie
        if (flow_stop_message) begin
            next_s.flow_stopped = 1'b1;
        end else if (flow_resume_message) begin
            next_s.flow_stopped = 1'b0;
        end
        if (!channel_up) begin
            next_s.flow_stopped = 1'b0;
        end
        // channel allocation by fixed priority
        next_s.clast = 1'b0;
        if (!channel_up) begin
            next_s.kind = slt_pkg::CK_IDLE;
        end else if (clock_correction_request) begin
            next_s.kind = slt_pkg::CK_CC;
        end else if (nfc_tx_tvalid) begin
            next_s.kind = slt_pkg::CK_NFC;
        end else if (ufc_tx_req) begin
            next_s.kind = slt_pkg::CK_UFC;
        end else if (user_k_tx_tvalid) begin
            next_s.kind = slt_pkg::CK_USERK;
        end else if (fifo_pop) begin
            next_s.kind = slt_pkg::CK_DATA;
            {next_s.cdata, next_s.ckeep, next_s.clast} = fifo_out;
        end else begin
            next_s.kind = slt_pkg::CK_IDLE;
        end
        // transmit accept for the coming cycle
        next_s.tx_ready = channel_up && !clock_correction_request
            && !nfc_tx_tvalid && !ufc_tx_req
            && !user_k_tx_tvalid
            && !next_s.flow_stopped
            && (fifo_level <= slt_pkg::LEVEL_W'(slt_pkg::FIFO_DEPTH - 2));
        // receive stream
        next_s.rxv = link_rx_tvalid && channel_up;
        if (link_rx_tvalid) begin
            next_s.rxd = link_rx_tdata;
            next_s.rxk = link_rx_tkeep;
            next_s.rxl = link_rx_tlast;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign transceiver_reset = s.xcvr_reset;
    assign loopback_mode = s.loop;
    assign tx_lock = s.tx_lock;
    assign s_tx_tready = s.tx_ready;
    assign m_rx_tdata = s.rxd;
    assign m_rx_tkeep = s.rxk;
    assign m_rx_tlast = s.rxl;
    assign m_rx_tvalid = s.rxv;
    assign chan_kind = s.kind;
    assign chan_tdata = s.cdata;
    assign chan_tkeep = s.ckeep;
    assign chan_tlast = s.clast;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    a_flow_blocks_ready: assert property (
        (nfc_tx_tvalid || ufc_tx_req) |=> !s_tx_tready)
        else $error("transmit accept high after flow request");
    a_cc_takes_chan: assert property (
        (clock_correction_request && channel_up)
        |=> (chan_kind == slt_pkg::CK_CC) && !s_tx_tready)
        else $error("clock correction did not take the channel");
    a_userk_blocks: assert property (
        user_k_tx_tvalid |=> !s_tx_tready)
        else $error("transmit accept high during special block");
    a_stop_holds: assert property (
        s.flow_stopped |=> chan_kind != slt_pkg::CK_DATA)
        else $error("user data sent while flow stopped");
    a_rx_down_quiet: assert property (
        !channel_up |=> !m_rx_tvalid)
        else $error("receive valid while channel down");
    a_done_order: assert property (
        $rose(rx_reset_done) |-> tx_reset_done && $past(tx_reset_done))
        else $error("receive reset done before transmit reset done");
    a_lock_shown: assert property (
        $rose(pll_lock) |=> tx_lock)
        else $error("transmit lock did not follow pll lock");
    a_notlock_down: assert property (
        pll_not_locked |=> !lane_up && !channel_up && !tx_reset_done)
        else $error("link up while pll not locked");
    a_chan_after_lane: assert property (
        $rose(channel_up) |-> lane_up && $past(lane_up))
        else $error("channel up without lane up");
    a_loop_range: assert property (
        loopback_mode <= slt_pkg::LOOP_MAX)
        else $error("loopback mode out of range");
    a_down_no_ready: assert property (
        !channel_up |=> !s_tx_tready && (chan_kind != slt_pkg::CK_DATA))
        else $error("transmit accept high while channel down");
    a_nfc_over_userk: assert property (
        (channel_up && !clock_correction_request && nfc_tx_tvalid && user_k_tx_tvalid)
        |=> chan_kind == slt_pkg::CK_NFC)
        else $error("priority order broken");
    a_fifo_room: assert property (
        (s_tx_tvalid && s_tx_tready) |-> fifo_in_ready)
        else $error("transmit word accepted with buffer full");
endmodule : slt_top
`default_nettype wire

// file: design/slt_pkg.sv
// constants shared by the serial link transmit channel allocation block
`default_nettype none
package slt_pkg;
    // register map, byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    // control register fields
    localparam int CTRL_RESET_BIT = 0;
    localparam int CTRL_LOOP_LSB = 1;
    localparam logic [2:0] LOOP_NORMAL = 3'h0;
    localparam logic [2:0] LOOP_MAX = 3'h4;
    // status register fields
    localparam int ST_TX_LOCK = 0;
    localparam int ST_TX_DONE = 1;
    localparam int ST_RX_DONE = 2;
    localparam int ST_LANE_UP = 3;
    localparam int ST_CHAN_UP = 4;
    localparam int ST_FLOW_STOP = 5;
    localparam int ST_LEVEL_LSB = 8;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // channel user codes
    localparam logic [2:0] CK_IDLE = 3'h0;
    localparam logic [2:0] CK_CC = 3'h1;
    localparam logic [2:0] CK_NFC = 3'h2;
    localparam logic [2:0] CK_UFC = 3'h3;
    localparam logic [2:0] CK_USERK = 3'h4;
    localparam logic [2:0] CK_DATA = 3'h5;
    // stream and buffer shape
    localparam int DATA_W = 64;
    localparam int KEEP_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int LEVEL_W = 4;
    // bring-up timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int TX_RST_NS = 2000;
    localparam int RX_RST_NS = 3000;
    localparam int LANE_NS = 500;
    localparam int CHAN_NS = 500;
    localparam int TX_RST_CYC = (TX_RST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RX_RST_CYC = (RX_RST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LANE_CYC = (LANE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CHAN_CYC = (CHAN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 12;
endpackage : slt_pkg
`default_nettype wire

// file: design/slt_delay.sv
// one bring-up step: done rises a fixed number of cycles after start
`default_nettype none
module slt_delay #(
    parameter int CYCLES = 1
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic start,
    output logic done
);
    typedef struct packed {
        logic [slt_pkg::CNT_W-1:0] cnt;
        logic done;
    } slt_delay_state_type;

    slt_delay_state_type s;
    slt_delay_state_type next_s;

    always_comb begin
        next_s = s;
        if (!start) begin
            next_s = '0;
        end else if (!s.done) begin
            if (s.cnt == slt_pkg::CNT_W'(CYCLES - 1)) begin
                next_s.done = 1'b1;
            end else begin
                next_s.cnt = s.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign done = s.done;

    a_step_exact: assert property (@(posedge ref_clk) disable iff (!nrst)
        $rose(done) |-> $past(start, CYCLES))
        else $error("step finished without start held long enough");
endmodule : slt_delay
`default_nettype wire

// file: design/slt_fifo.sv
// small synchronous fifo with valid and ready on both sides
`default_nettype none
module slt_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
    } slt_fifo_state_type;

    slt_fifo_state_type s;
    slt_fifo_state_type next_s;
    logic push;
    logic pop;

    assign in_ready = (s.cnt != (PW+1)'(DEPTH));
    assign out_valid = (s.cnt != '0);
    assign out_data = s.mem[s.rp];
    assign level = s.cnt;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wp] = in_data;
            next_s.wp = s.wp + 1'b1;
        end
        if (pop) begin
            next_s.rp = s.rp + 1'b1;
        end
        if (push && !pop) begin
            next_s.cnt = s.cnt + 1'b1;
        end else if (pop && !push) begin
            next_s.cnt = s.cnt - 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule : slt_fifo
`default_nettype wire

// file: testbench/slt_src.sv
// stream source standing in for the user logic on the transmit side
`default_nettype none
module slt_src (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic en,
    input wire logic tready,
    output logic [63:0] tdata,
    output logic [7:0] tkeep,
    output logic tlast,
    output var logic tvalid,
    output var logic [15:0] sent
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////
    // word n carries n; every fourth word closes a frame
    assign tlast = tvalid & (sent[1:0] == 2'h3);
    assign tkeep = tlast ? 8'h0f : 8'hff;
    assign tdata = tvalid ? {48'h0, sent} : {48'hffff_0000_ffff, ~sent};
    always @(posedge ref_clk) begin
        if (!nrst) begin
            tvalid <= 1'b0;
            sent <= 16'h0;
        end else begin
            if (tvalid && tready) begin
                sent <= sent + 16'h1;
            end
            if (!tvalid || tready) begin
                tvalid <= en;
            end
        end
    end
endmodule : slt_src
`default_nettype wire

// file: testbench/slt_top_tb_top.sv
// self-checking bench for the link transmit channel allocation block
`default_nettype none
module slt_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, nrst = 1'b0, en = 1'b0, stop = 1'b0, resume = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0, lrx_k = 8'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic awready, wready, bvalid, arready, rvalid, tready, tvalid, tlast, m_v, m_l;
    logic [1:0] bresp, rresp, r;
    logic pll_lock = 1'b1, pll_nl = 1'b0, lrx_v = 1'b0;
    logic cc = 1'b0, nfc = 1'b0, ufc = 1'b0, usk = 1'b0;
    logic [63:0] lrx_d = 64'h0, tdata, m_d, p_rxd, c_d;
    logic [7:0] tkeep, m_k, p_rxk, c_k;
    logic [2:0] loop, kind;
    logic xr, lock, txd, rxd, lane, up, c_l, p_on, p_lock, p_up, p_rxv, p_blk;
    logic [15:0] sent, rcv = 16'h0, r0;
    logic [7:0] rows [6] = '{8'h01, 8'h82, 8'h74, 8'h36, 8'h18, 8'hf2};
    int err_count = 0, check_count = 0;
    always #2 ref_clk = ~ref_clk;
    slt_top u_dut (.ref_clk(ref_clk), .nrst(nrst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pll_lock(pll_lock), .pll_not_locked(pll_nl),
        .transceiver_reset(xr), .loopback_mode(loop), .tx_lock(lock), .tx_reset_done(txd),
        .rx_reset_done(rxd), .lane_up(lane), .channel_up(up),
        .clock_correction_request(cc), .nfc_tx_tvalid(nfc), .ufc_tx_req(ufc),
        .user_k_tx_tvalid(usk), .s_tx_tdata(tdata), .s_tx_tkeep(tkeep),
        .s_tx_tlast(tlast), .s_tx_tvalid(tvalid), .s_tx_tready(tready),
        .flow_stop_message(stop), .flow_resume_message(resume), .link_rx_tdata(lrx_d),
        .link_rx_tkeep(lrx_k), .link_rx_tlast(lrx_k[0]), .link_rx_tvalid(lrx_v),
        .m_rx_tdata(m_d), .m_rx_tkeep(m_k), .m_rx_tlast(m_l), .m_rx_tvalid(m_v),
        .chan_kind(kind), .chan_tdata(c_d), .chan_tkeep(c_k), .chan_tlast(c_l));
    slt_src u_src (.ref_clk(ref_clk), .nrst(nrst), .en(en), .tready(tready), .tdata(tdata),
        .tkeep(tkeep), .tlast(tlast), .tvalid(tvalid), .sent(sent));
    ////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [79:0] seen, input logic [79:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_rd
    task automatic bring_up();
        int n;
        n = 0;
        while (up !== 1'b1 && n < 4000) begin
            @(posedge ref_clk);
            n++;
        end
        check("uptime", n >= 1450 && n <= 2300, 1'b1);
    endtask : bring_up
    task automatic drain();
        en <= 1'b0;
        repeat (200) if (tvalid || rcv != sent) @(posedge ref_clk);
        check("drain", rcv, sent);
    endtask : drain
    task automatic pulse(input logic go);
        if (go) begin
            resume <= 1'b1;
        end else begin
            stop <= 1'b1;
        end
        @(posedge ref_clk);
        resume <= 1'b0;
        stop <= 1'b0;
    endtask : pulse
    ////////////////////////////////////////////////////////////////
    // receive traffic, and per-cycle checks of the stream sides
    always @(posedge ref_clk) begin
        lrx_d <= lrx_d + 64'h1;
        lrx_k <= lrx_k + 8'h3;
        lrx_v <= ~lrx_v;
        if (nrst && p_on) begin
            if (tready) check("blk", p_blk, 1'b0);
            check("ord", {rxd & ~txd, lane & ~rxd, up & ~lane}, 3'h0);
            check("txl", lock, p_lock);
            if (p_up && up) check("rxv", m_v, p_rxv);
            if (p_up && up && p_rxv) begin
                check("rxd", {m_k, m_l, m_d}, {p_rxk, p_rxk[0], p_rxd});
            end
            if (kind === slt_pkg::CK_DATA) begin
                check("dat", {c_l, c_k, c_d}, {rcv[1:0] == 2'h3,
                    (rcv[1:0] == 2'h3) ? 8'h0f : 8'hff, 48'h0, rcv});
                rcv <= rcv + 16'h1;
            end else begin
                check("lst", c_l, 1'b0);
            end
        end
        p_on <= nrst;
        p_lock <= pll_lock;
        p_up <= up;
        p_rxv <= lrx_v;
        p_rxd <= lrx_d;
        p_rxk <= lrx_k;
        p_blk <= cc | nfc | ufc | usk | ~up;
    end
    initial begin
        #100us;
        err_count++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check("rst", {up, tready, bvalid, rvalid, kind}, 7'h0);
        bring_up();
        axi_rd(slt_pkg::REG_STATUS);
        check("st", {r, d[4:0]}, {slt_pkg::RESP_OKAY, 5'h1f});
        foreach (rows[i]) begin
            {cc, nfc, ufc, usk} <= rows[i][7:4];
            repeat (2) @(posedge ref_clk);
            check("kind", kind, rows[i][3:1]);
            check("rdy", tready, rows[i][0]);
        end
        {cc, nfc, ufc, usk} <= 4'h0;
        for (int i = 0; i < 6; i++) begin
            axi_wr(slt_pkg::REG_CTRL, 32'(i) << 1);
            axi_rd(slt_pkg::REG_CTRL);
            check("loop", {d[3:1], loop}, (i > 4) ? 6'h24 : {2{3'(i)}});
        end
        axi_wr(8'h10, 32'h0);
        check("wresp", r, slt_pkg::RESP_SLVERR);
        axi_rd(8'h10);
        check("rresp", {r, d}, {slt_pkg::RESP_SLVERR, 32'h0});
        axi_wr(slt_pkg::REG_STATUS, 32'h0);
        check("ro", r, slt_pkg::RESP_OKAY);
        en <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            cc <= (i % 3 == 0);
            @(posedge ref_clk);
        end
        cc <= 1'b0;
        drain();
        en <= 1'b1;
        repeat (5) @(posedge ref_clk);
        pulse(1'b0);
        repeat (3) @(posedge ref_clk);
        r0 = rcv;
        repeat (20) @(posedge ref_clk);
        check("stop", {tready, rcv}, {1'b0, r0});
        axi_rd(slt_pkg::REG_STATUS);
        check("lvl", {d[5], d[11:8]}, {1'b1, 4'(sent - rcv)});
        pulse(1'b1);
        drain();
        axi_wr(slt_pkg::REG_CTRL, 32'h1);
        repeat (3) @(posedge ref_clk);
        check("crst", {xr, up, lane, tready}, 4'h8);
        axi_wr(slt_pkg::REG_CTRL, 32'h0);
        bring_up();
        pll_nl <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check("nlck", {xr, up, lane, tready}, 4'h8);
        pll_nl <= 1'b0;
        bring_up();
        pll_lock <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check("plck", {lock, up}, 2'h0);
        pll_lock <= 1'b1;
        bring_up();
        summarize();
    end
endmodule : slt_top_tb_top
`default_nettype wire
